// ---- rtl/tsb_top.sv ----
// Trigger control and service summary byte of the remote-control interface.
// Assumes a command decoder on clk_sys delivers one-cycle strobes; the two
// trigger pins are asynchronous and are synchronised here.
//
// Summary of operation
// - Trigger delay 0 to 999.999 s in 1 ms steps, stored value readable.
// - After a trigger is taken, wait the programmed delay, then start measuring.
// - Immediate trigger while waiting starts exactly one measurement.
// - Immediate trigger with internal source or when not waiting flags an error.
// - Four selectable trigger sources: internal, front key, handler pin, bus; readable.
// - Summary bits gated by the enable mask; any valid bit raises a service request.
// - Bit 6 is request-service on serial poll, master summary on query.
// - Bit 7 set by enabled operation events, cleared by device clear or read.
// - Bit 5 follows whether any enabled standard event bit is one.
// - Bit 4 set while a query response waits for output.
// - Bits 3 down to 0 always read zero.
// - Bit 6 set on service request; cleared only by device clear or serial poll, not when the summary falls to zero.
// - Status query returns the weighted sum of all set bits.
`timescale 1ns/1ps
`default_nettype none
module tsb_top #(
    parameter int unsigned CYC_PER_MS = tsb_pkg::CYC_PER_STEP
) (
    // Clock and reset
    input  wire logic                         clk_sys,
    input  wire logic                         sys_rst,
    input  wire logic                         clk_en,
    // Trigger settings
    input  wire logic                         delay_wr,
    input  wire logic [tsb_pkg::DELAY_W-1:0]  delay_ms_in,
    output logic      [tsb_pkg::DELAY_W-1:0]  delay_ms_out,
    input  wire logic                         src_wr,
    input  wire logic [1:0]                   src_in,
    output logic      [1:0]                   src_out,
    output logic                              delay_err,
    // Trigger events
    input  wire logic                         trigger_input_signal_imm,
    input  wire logic                         bus_trg,
    input  wire logic                         front_panel_key,
    input  wire logic                         trigger_input_signal,
    output logic                              trigger_input_signal_imm_err,
    // Measurement engine
    input  wire logic                         meas_done,
    output logic                              meas_start,
    output logic                              trigger_input_signal_waiting,
    output logic                              trigger_input_signal_delaying,
    // Status summary sources
    input  wire logic                         oper_summary,
    input  wire logic                         std_summary,
    input  wire logic                         resp_ready,
    // Status access
    input  wire logic                         sre_wr,
    input  wire logic [7:0]                   sre_in,
    output logic      [7:0]                   sre_out,
    input  wire logic                         stb_query,
    input  wire logic                         serial_poll,
    input  wire logic                         device_clear,
    output logic      [7:0]                   stb_value,
    output logic      [7:0]                   poll_value,
    output logic                              service_req
);

    typedef struct packed {
        logic [2:0]                  fp_sync;
        logic [2:0]                  hs_sync;
        tsb_pkg::tsb_state_e         state;
        logic [tsb_pkg::DELAY_W-1:0] delay_ms;
        logic [1:0]                  src;
        logic                        start;
        logic                        imm_err;
        logic                        dly_err;
        logic [7:0]                  sre;
        logic                        oper_bit;
        logic                        oper_d;
        logic                        rqs;
        logic                        svc_d;
        logic [7:0]                  stb;
        logic [7:0]                  poll;
    } tsb_top_s;

    tsb_top_s cur_ff;
    tsb_top_s nxt_top;

    logic       tmr_busy;
    logic       tmr_done;
    logic       fp_edge;
    logic       hs_edge;
    logic       src_trigger_input_signal;
    logic       imm_ok;
    logic [7:0] summary;
    logic       svc_cond;

    // ------------------------------------------------------------
    // Delay timer
    // ------------------------------------------------------------
    tsb_delay_timer #(
        .CYC_PER_MS (CYC_PER_MS)
    ) u_timer (
        .clk_sys  (clk_sys),
        .sys_rst  (sys_rst),
        .clk_en   (clk_en),
        .start    (cur_ff.start),
        .delay_ms (cur_ff.delay_ms),
        .busy     (tmr_busy),
        .done     (tmr_done)
    );

    // ------------------------------------------------------------
    // Trigger qualification
    // ------------------------------------------------------------
    // Edges use stages 1 and 2 only; stage 0 feeds nothing but stage 1
    assign fp_edge = cur_ff.fp_sync[1] & ~cur_ff.fp_sync[2];
    assign hs_edge = cur_ff.hs_sync[1] & ~cur_ff.hs_sync[2];

    always_comb begin
        case (cur_ff.src)
            tsb_pkg::SRC_FRONT:   src_trigger_input_signal = fp_edge;
            tsb_pkg::SRC_HANDLER: src_trigger_input_signal = hs_edge;
            tsb_pkg::SRC_BUS:     src_trigger_input_signal = bus_trg;
            default:              src_trigger_input_signal = 1'b1;  // internal runs continuously
        endcase
    end

    assign imm_ok = trigger_input_signal_imm && cur_ff.state == tsb_pkg::TSB_ST_WAIT
                    && cur_ff.src != tsb_pkg::SRC_INTERNAL;

    // ------------------------------------------------------------
    // Service summary
    // ------------------------------------------------------------
    assign summary  = {cur_ff.oper_bit, 1'b0, std_summary, resp_ready,
                       4'h0};
    assign svc_cond = |(summary & cur_ff.sre & tsb_pkg::SUMMARY_MASK);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_top         = cur_ff;
        nxt_top.fp_sync = {cur_ff.fp_sync[1:0], front_panel_key};
        nxt_top.hs_sync = {cur_ff.hs_sync[1:0], trigger_input_signal};
        nxt_top.start   = 1'b0;
        nxt_top.imm_err = 1'b0;
        nxt_top.dly_err = 1'b0;
        nxt_top.oper_d  = oper_summary;
        nxt_top.svc_d   = svc_cond;

        if (delay_wr) begin
            if (delay_ms_in > tsb_pkg::DELAY_MAX_MS) begin
                nxt_top.dly_err = 1'b1;  // Out of range keeps the old value
            end else begin
                nxt_top.delay_ms = delay_ms_in;
            end
        end
        if (src_wr) begin
            nxt_top.src = src_in;
        end
        if (sre_wr) begin
            nxt_top.sre = sre_in;
        end

        if (trigger_input_signal_imm && !imm_ok) begin
            nxt_top.imm_err = 1'b1;
        end

        case (cur_ff.state)
            tsb_pkg::TSB_ST_WAIT: begin
                if (src_trigger_input_signal || imm_ok) begin
                    nxt_top.start = 1'b1;
                    nxt_top.state = tsb_pkg::TSB_ST_DELAY;
                end
            end
            tsb_pkg::TSB_ST_DELAY: begin
                if (tmr_done) begin
                    nxt_top.state = tsb_pkg::TSB_ST_MEAS;
                end
            end
            tsb_pkg::TSB_ST_MEAS: begin
                if (meas_done) begin
                    nxt_top.state = tsb_pkg::TSB_ST_WAIT;
                end
            end
            default: begin
                nxt_top.state = tsb_pkg::TSB_ST_WAIT;
            end
        endcase

        // Snapshots for the two read paths
        if (stb_query) begin
            nxt_top.stb = summary | {1'b0, svc_cond, 6'h00};
        end
        if (serial_poll) begin
            nxt_top.poll = summary | {1'b0, cur_ff.rqs, 6'h00};
        end

        // Clear first so that a new event in the same cycle wins
        if (device_clear || stb_query || serial_poll) begin
            nxt_top.oper_bit = 1'b0;
        end
        if (oper_summary && !cur_ff.oper_d) begin
            nxt_top.oper_bit = 1'b1;
        end

        if (device_clear || serial_poll) begin
            nxt_top.rqs = 1'b0;
        end
        if (svc_cond && !cur_ff.svc_d) begin
            nxt_top.rqs = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cur_ff          <= '0;
            cur_ff.state    <= tsb_pkg::TSB_ST_WAIT;
            cur_ff.delay_ms <= tsb_pkg::DELAY_RST;
            cur_ff.src      <= tsb_pkg::SRC_RST;
            cur_ff.sre      <= tsb_pkg::SRE_RST;
        end else if (clk_en) begin
            cur_ff <= nxt_top;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign delay_ms_out  = cur_ff.delay_ms;
    assign src_out       = cur_ff.src;
    assign delay_err     = cur_ff.dly_err;
    assign trigger_input_signal_imm_err  = cur_ff.imm_err;
    // Start is taken from the timer's done pulse so no cycle is lost
    assign meas_start    = tmr_done;
    assign trigger_input_signal_waiting  = cur_ff.state == tsb_pkg::TSB_ST_WAIT;
    // Drops with the done pulse: the delay is over once measuring starts
    assign trigger_input_signal_delaying = (cur_ff.state == tsb_pkg::TSB_ST_DELAY && !tmr_done) || tmr_busy;
    assign sre_out       = cur_ff.sre;
    assign stb_value     = cur_ff.stb;
    assign poll_value    = cur_ff.poll;
    assign service_req   = cur_ff.rqs;

endmodule : tsb_top
`default_nettype wire

// ---- rtl/tsb_pkg.sv ----
// Constants shared by the trigger controller and its delay timer.
// Assumes a single 20 MHz system clock.
package tsb_pkg;

    // ------------------------------------------------------------
    // Clock and time base
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned DELAY_STEP_NS = 1000000;  // 0.001 s resolution
    localparam int unsigned CYC_PER_STEP  = DELAY_STEP_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Trigger delay
    // ------------------------------------------------------------
    localparam int unsigned DELAY_W       = 20;
    localparam logic [19:0] DELAY_MAX_MS  = 20'hf423f;  // 999.999 s in ms
    localparam logic [19:0] DELAY_RST     = 20'h00000;

    // ------------------------------------------------------------
    // Trigger source codes
    // ------------------------------------------------------------
    localparam logic [1:0]  SRC_INTERNAL  = 2'h0;
    localparam logic [1:0]  SRC_FRONT     = 2'h1;  // front_panel_source
    localparam logic [1:0]  SRC_HANDLER   = 2'h2;  // handler_source
    localparam logic [1:0]  SRC_BUS       = 2'h3;
    localparam logic [1:0]  SRC_RST       = 2'h0;

    // ------------------------------------------------------------
    // Service summary byte layout
    // ------------------------------------------------------------
    localparam int unsigned BIT_OPER      = 7;  // operation_summary_bit
    localparam int unsigned BIT_SVC       = 6;  // request-service / master summary
    localparam int unsigned BIT_STD       = 5;
    localparam int unsigned BIT_MAV       = 4;
    localparam int unsigned BIT_QUEUE     = 3;  // queue_summary_bit, always zero
    localparam logic [7:0]  SRE_RST       = 8'h00;
    localparam logic [7:0]  SUMMARY_MASK  = 8'hb0;  // bits that may raise service

    typedef enum logic [1:0] {
        TSB_ST_WAIT,
        TSB_ST_DELAY,
        TSB_ST_MEAS
    } tsb_state_e;

endpackage : tsb_pkg

// ---- rtl/tsb_delay_timer.sv ----
// Millisecond down-counter for the trigger-to-measurement delay.
// Assumes start is a one-cycle pulse on clk_sys.
`timescale 1ns/1ps
`default_nettype none
module tsb_delay_timer #(
    parameter int unsigned CYC_PER_MS = tsb_pkg::CYC_PER_STEP
) (
    // Clock and reset
    input  wire logic                         clk_sys,
    input  wire logic                         sys_rst,
    input  wire logic                         clk_en,
    // Control
    input  wire logic                         start,
    input  wire logic [tsb_pkg::DELAY_W-1:0]  delay_ms,
    // Status
    output logic                              busy,
    output logic                              done
);

    typedef struct packed {
        logic                        busy;
        logic                        done;
        logic [tsb_pkg::DELAY_W-1:0] ms_left;
        logic [31:0]                 pre;
    } tsb_tmr_s;

    tsb_tmr_s cur_ff;
    tsb_tmr_s nxt_tmr;

    always_comb begin
        nxt_tmr      = cur_ff;
        nxt_tmr.done = 1'b0;
        if (start) begin
            nxt_tmr.busy    = 1'b1;
            nxt_tmr.ms_left = delay_ms;
            nxt_tmr.pre     = 32'h0;
        end else if (cur_ff.busy) begin
            if (cur_ff.ms_left == '0) begin
                nxt_tmr.busy = 1'b0;
                nxt_tmr.done = 1'b1;
            end else if (cur_ff.pre == CYC_PER_MS - 1) begin
                nxt_tmr.pre     = 32'h0;
                nxt_tmr.ms_left = cur_ff.ms_left - 1'b1;
            end else begin
                nxt_tmr.pre = cur_ff.pre + 32'h1;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cur_ff <= '0;
        end else if (clk_en) begin
            cur_ff <= nxt_tmr;
        end
    end

    assign busy = cur_ff.busy;
    assign done = cur_ff.done;

endmodule : tsb_delay_timer
`default_nettype wire

// ---- tb/tsb_top_sva.sv ----
// Port-level assertions for tsb_top.
// Assumes it is bound into tsb_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module tsb_top_sva #(
    parameter int unsigned CYC_PER_MS = 4
) (
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        sys_rst,
    input wire logic        clk_en,
    // Settings
    input wire logic        delay_wr,
    input wire logic [19:0] delay_ms_in,
    input wire logic [19:0] delay_ms_out,
    input wire logic        delay_err,
    input wire logic        src_wr,
    input wire logic [1:0]  src_in,
    input wire logic [1:0]  src_out,
    // Triggering
    input wire logic        trigger_input_signal_imm,
    input wire logic        bus_trg,
    input wire logic        trigger_input_signal_imm_err,
    input wire logic        meas_start,
    input wire logic        trigger_input_signal_waiting,
    input wire logic        trigger_input_signal_delaying,
    // Status
    input wire logic        std_summary,
    input wire logic        resp_ready,
    input wire logic        stb_query,
    input wire logic        serial_poll,
    input wire logic [7:0]  stb_value,
    input wire logic [7:0]  poll_value,
    input wire logic        service_req
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    property p_dly_bad;
        delay_wr && clk_en && delay_ms_in > tsb_pkg::DELAY_MAX_MS
            |=> delay_err && $stable(delay_ms_out);
    endproperty
    a_dly_bad: assert property (p_dly_bad) else $error("bad delay accepted");
    property p_dly_ok;
        delay_wr && clk_en && delay_ms_in <= tsb_pkg::DELAY_MAX_MS
            |=> delay_ms_out == $past(delay_ms_in) && !delay_err;
    endproperty
    a_dly_ok: assert property (p_dly_ok) else $error("delay not stored");
    property p_src;
        src_wr && clk_en |=> src_out == $past(src_in);
    endproperty
    a_src: assert property (p_src) else $error("source not stored");
    property p_imm_bad;
        trigger_input_signal_imm && clk_en && (src_out == tsb_pkg::SRC_INTERNAL || !trigger_input_signal_waiting)
            |=> trigger_input_signal_imm_err;
    endproperty
    a_imm_bad: assert property (p_imm_bad) else $error("immediate not refused");
    property p_imm_ok;
        trigger_input_signal_imm && clk_en && trigger_input_signal_waiting && src_out != tsb_pkg::SRC_INTERNAL
            |=> !trigger_input_signal_imm_err && trigger_input_signal_delaying;
    endproperty
    a_imm_ok: assert property (p_imm_ok) else $error("immediate not taken");
    property p_bus_go;
        trigger_input_signal_waiting && bus_trg && clk_en && src_out == tsb_pkg::SRC_BUS
            |=> trigger_input_signal_delaying && !trigger_input_signal_waiting;
    endproperty
    a_bus_go: assert property (p_bus_go) else $error("bus trigger lost");
    property p_meas;
        meas_start |-> !trigger_input_signal_waiting && !trigger_input_signal_delaying;
    endproperty
    a_meas: assert property (p_meas) else $error("start while idle");
    property p_low;
        stb_value[3:0] == 4'h0 && poll_value[3:0] == 4'h0;
    endproperty
    a_low: assert property (p_low) else $error("low status bits set");
    property p_stb;
        stb_query && clk_en |=> stb_value[5] == $past(std_summary)
            && stb_value[4] == $past(resp_ready);
    endproperty
    a_stb: assert property (p_stb) else $error("status bits 5..4 wrong");
    property p_poll;
        serial_poll && clk_en |=> poll_value[6] == $past(service_req);
    endproperty
    a_poll: assert property (p_poll) else $error("poll bit 6 wrong");

    c_bus: cover property (trigger_input_signal_waiting && bus_trg && src_out == tsb_pkg::SRC_BUS);
    c_imm: cover property (trigger_input_signal_imm_err);
    c_poll: cover property (serial_poll && service_req);
endmodule : tsb_top_sva

bind tsb_top tsb_top_sva #(.CYC_PER_MS(CYC_PER_MS)) i_tsb_top_sva (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en), .delay_wr(delay_wr),
    .delay_ms_in(delay_ms_in), .delay_ms_out(delay_ms_out), .delay_err(delay_err),
    .src_wr(src_wr), .src_in(src_in), .src_out(src_out), .trigger_input_signal_imm(trigger_input_signal_imm),
    .bus_trg(bus_trg), .trigger_input_signal_imm_err(trigger_input_signal_imm_err), .meas_start(meas_start),
    .trigger_input_signal_waiting(trigger_input_signal_waiting), .trigger_input_signal_delaying(trigger_input_signal_delaying),
    .std_summary(std_summary), .resp_ready(resp_ready), .stb_query(stb_query),
    .serial_poll(serial_poll), .stb_value(stb_value), .poll_value(poll_value),
    .service_req(service_req)
);
`default_nettype wire

// ---- tb/tsb_meas_model.sv ----
// Behavioural measurement engine on the far side of meas_start.
// Assumes meas_start is a one-cycle pulse on clk_sys.
`timescale 1ns/1ps
`default_nettype none
module tsb_meas_model #(
    parameter int unsigned LAT = 3
) (
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    input  wire logic meas_start,
    output var logic  meas_done
);
    int cnt;
    // Never finishes early, so a lost start shows up as a hang
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cnt <= 0;
            meas_done <= 1'b0;
        end else begin
            meas_done <= (cnt == 1);
            if (meas_start) cnt <= int'(LAT);
            else if (cnt > 0) cnt <= cnt - 1;
        end
    end
endmodule : tsb_meas_model
`default_nettype wire

// ---- tb/test_tsb_top.sv ----
// Self-checking bench for tsb_top with a measurement engine model.
// Assumes CYC_PER_MS of 4 so trigger delays stay short.
`timescale 1ns/1ps
`default_nettype none
module test_tsb_top;
    logic        clk_sys = 1'b0;
    logic        sys_rst = 1'b1;
    logic        clk_en  = 1'b1;
    logic [7:0]  cmd     = 8'h00;
    logic [19:0] dly_in  = 20'h00000;
    logic [1:0]  src_in  = 2'h0;
    logic [7:0]  sre_in  = 8'h00;
    logic        fp_key  = 1'b0;
    logic        hnd_pin = 1'b0;
    logic        evt_op  = 1'b0;
    logic        evt_std = 1'b0;
    logic        evt_rsp = 1'b0;
    logic        meas_done, dly_err, imm_err, meas_start, waiting, delaying, srq;
    logic [19:0] dly_out;
    logic [1:0]  src_out;
    logic [7:0]  sre_out, stb_v, poll_v;
    int          bad_count = 0;
    int          n_checks  = 0;
    int          n_meas    = 0;

    tsb_top #(.CYC_PER_MS(4)) i_tsb_top (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en),
        .delay_wr(cmd[0]), .delay_ms_in(dly_in), .delay_ms_out(dly_out),
        .src_wr(cmd[1]), .src_in(src_in), .src_out(src_out), .delay_err(dly_err),
        .trigger_input_signal_imm(cmd[2]), .bus_trg(cmd[3]), .front_panel_key(fp_key),
        .trigger_input_signal(hnd_pin), .trigger_input_signal_imm_err(imm_err),
        .meas_done(meas_done), .meas_start(meas_start), .trigger_input_signal_waiting(waiting),
        .trigger_input_signal_delaying(delaying), .oper_summary(evt_op), .std_summary(evt_std),
        .resp_ready(evt_rsp), .sre_wr(cmd[4]), .sre_in(sre_in), .sre_out(sre_out),
        .stb_query(cmd[5]), .serial_poll(cmd[6]), .device_clear(cmd[7]),
        .stb_value(stb_v), .poll_value(poll_v), .service_req(srq)
    );
    tsb_meas_model i_tsb_meas_model (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .meas_start(meas_start),
        .meas_done(meas_done)
    );

    always #25 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (meas_start === 1'b1) n_meas++;

    task automatic chk(input string nm, input logic [19:0] e, input logic [19:0] g);
        n_checks++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", nm, e, g);
            bad_count++;
        end
    endtask : chk
    // One strobe; its data goes to every data input at once
    task automatic pulse(input int b, input logic [19:0] d);
        @(posedge clk_sys);
        cmd[b] <= 1'b1;
        dly_in <= d;
        src_in <= d[1:0];
        sre_in <= d[7:0];
        @(posedge clk_sys);
        cmd <= 8'h00;
        #1;
    endtask : pulse
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : step
    task automatic lvl(input logic [2:0] v);
        @(posedge clk_sys);
        {evt_op, evt_std, evt_rsp} <= v;
        #1;
    endtask : lvl
    task automatic wait_idle;
        for (int n = 0; n < 100 && waiting !== 1'b1; n++) step(1);
        chk("waiting", 20'h1, {19'h0, waiting});
    endtask : wait_idle

    task automatic t_delay;
        pulse(0, 20'hf423f);
        chk("delay_max", 20'hf423f, dly_out);
        pulse(0, 20'hf4240);
        chk("delay_err", 20'h1, {19'h0, dly_err});
        chk("delay_kept", 20'hf423f, dly_out);
        pulse(0, 20'h00002);
        for (int s = 0; s < 4; s++) begin
            pulse(1, 20'(s));
            chk("source", 20'(s), {18'h0, src_out});
        end
        $display("t_delay done");
    endtask : t_delay

    // Delay 2 ms at 4 cycles each; pins pay two extra sync edges
    task automatic t_trigger_input_signal;
        int n, m0;
        for (int s = 1; s < 4; s++) begin
            pulse(1, 20'(s));
            wait_idle();
            @(posedge clk_sys);
            fp_key <= (s == 1);
            hnd_pin <= (s == 2);
            cmd[3] <= (s == 3);
            @(posedge clk_sys);
            {fp_key, hnd_pin, cmd[3]} <= 3'h0;
            #1;
            if (s == 3) chk("delaying", 20'h1, {19'h0, delaying});
            n = 0;
            while (meas_start !== 1'b1 && n < 100) begin
                step(1);
                n++;
            end
            chk("trigger_input_signal_to_meas", (s == 3) ? 20'd10 : 20'd12, 20'(n));
            wait_idle();
            m0 = n_meas;
            step(6);
            chk("no_retrigger", 20'h0, 20'(n_meas - m0));
        end
        // Held enable must ignore a write
        @(posedge clk_sys);
        clk_en <= 1'b0;
        pulse(0, 20'h00005);
        chk("frozen", 20'h00002, dly_out);
        @(posedge clk_sys);
        clk_en <= 1'b1;
        #1;
        $display("t_trigger_input_signal done");
    endtask : t_trigger_input_signal

    task automatic t_imm;
        int m0;
        m0 = n_meas;
        pulse(2, 20'h0);
        chk("imm_ok", 20'h0, {19'h0, imm_err});
        pulse(2, 20'h0);
        chk("imm_busy", 20'h1, {19'h0, imm_err});
        wait_idle();
        chk("one_meas", 20'h1, 20'(n_meas - m0));
        pulse(1, 20'h0);
        pulse(2, 20'h0);
        chk("imm_int", 20'h1, {19'h0, imm_err});
        $display("t_imm done");
    endtask : t_imm

    task automatic t_stb;
        pulse(4, 20'hb0);
        chk("sre", 20'hb0, {12'h0, sre_out});
        lvl(3'b010);
        step(2);
        chk("srq_std", 20'h1, {19'h0, srq});
        pulse(5, 20'h0);
        chk("stb_std", 20'h60, {12'h0, stb_v});
        pulse(6, 20'h0);
        chk("poll_std", 20'h60, {12'h0, poll_v});
        lvl(3'b101);
        step(2);
        pulse(5, 20'h0);
        chk("stb_oper", 20'hd0, {12'h0, stb_v});
        pulse(5, 20'h0);
        chk("stb_reread", 20'h50, {12'h0, stb_v});
        pulse(6, 20'h0);
        chk("poll_mav", 20'h1, {19'h0, poll_v[4]});
        lvl(3'b100);
        pulse(6, 20'h0);
        chk("poll_mav_gone", 20'h0, {19'h0, poll_v[4]});
        lvl(3'b000);
        lvl(3'b100);
        step(2);
        chk("srq_oper", 20'h1, {19'h0, srq});
        pulse(7, 20'h0);
        chk("srq_clear", 20'h0, {19'h0, srq});
        pulse(4, 20'h0);
        lvl(3'b010);
        step(2);
        pulse(5, 20'h0);
        chk("stb_masked", 20'h20, {12'h0, stb_v});
        chk("srq_masked", 20'h0, {19'h0, srq});
        $display("t_stb done");
    endtask : t_stb

    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report

    initial begin
        repeat (6) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_delay();
        t_trigger_input_signal();
        t_imm();
        t_stb();
        final_report();
    end
    // Whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk_sys);
        bad_count++;
        final_report();
    end
endmodule : test_tsb_top
`default_nettype wire
